// ---- hdl/lfp_fault_ctrl.sv ----
// Fault supervision and shutdown sequencing for a four-string boost LED driver.
`timescale 1ns/1ps
`default_nettype none
module lfp_fault_ctrl #(
  parameter int N             = lfp_pkg::NUM_STRINGS,
  parameter int INPUT_UNDERVOLTAGE_LOCKOUT_FILT_CYC = lfp_pkg::INPUT_UNDERVOLTAGE_LOCKOUT_FILT_CYC,
  parameter int LOWPOWER_CYC  = lfp_pkg::LOWPOWER_CYC,
  parameter int LIMIT_1X_CYC  = lfp_pkg::LIMIT_1X_CYC,
  parameter int DETECT_CYC    = lfp_pkg::DETECT_CYC
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         dimEnablePin,
  input  wire logic         freqSetSyncPin,
  input  wire logic [N-1:0] sinkShortPin,
  input  wire logic [N-1:0] sinkOpenPin,
  input  wire logic         ovSensePin,
  input  wire logic         switchNodeOverPin,
  input  wire logic         switchLimitPin,
  input  wire logic         switchLimit2Pin,
  input  wire logic         inputOver1xPin,
  input  wire logic         inputOver2xPin,
  input  wire logic         inputUnderPin,
  output logic              boostEnable_ff,
  output logic              boostCutCycle_ff,
  output logic [N-1:0]      sinkEnable_ff,
  output logic              disconnectGateOn_ff,
  output logic              disconnectLimit_ff,
  output logic              faultFlag_ff,
  output logic              lowPower_ff
);

  // ==========================================================================
  // Parameter checks
  // ==========================================================================
  localparam int TW = lfp_pkg::TIMER_W;
  localparam int SW = 2 * N + 9;

  generate
    if (N < 1 || DETECT_CYC < 1 || DETECT_CYC >= (2 ** TW)) begin : g_bad
      $error("lfp_fault_ctrl parameters out of range");
    end
  endgenerate

  // ==========================================================================
  // Pin synchronisation
  // ==========================================================================
  logic [SW-1:0] pinSync;
  logic [N-1:0]  shortS;
  logic [N-1:0]  openS;
  logic dimS, syncS, ovS, swOverS, limS, lim2S, in1xS, in2xS, underS;

  // All comparator and host pins arrive from outside the clock domain.
  lfp_sync #(
    .W (SW)
  ) u_sync (
    .clock       (clock),
    .rst         (rst),
    .pinIn       ({sinkShortPin, sinkOpenPin, dimEnablePin, freqSetSyncPin,
                   ovSensePin, switchNodeOverPin, switchLimitPin,
                   switchLimit2Pin, inputOver1xPin, inputOver2xPin,
                   inputUnderPin}),
    .levelOut_ff (pinSync)
  );

  assign {shortS, openS, dimS, syncS, ovS, swOverS, limS, lim2S,
          in1xS, in2xS, underS} = pinSync;

  // ==========================================================================
  // State and records
  // ==========================================================================
  lfp_pkg::lfp_state_type state_ff, nxt_state;
  logic [TW-1:0] detCnt_ff;
  logic [N-1:0]  shortOut_ff;
  logic [N-1:0]  openOut_ff;
  logic          dimPrev_ff;
  logic          dimRise, active, limitCond, latchCause;
  logic          syncLowHit, uvloHit, dimLowHit, limitHit;

  // Rising edge of the synchronised dimming-enable level.
  always_ff @(posedge clock) begin
    if (rst) begin
      dimPrev_ff <= 1'b0;
    end else begin
      dimPrev_ff <= dimS;
    end
  end

  assign dimRise = dimS && !dimPrev_ff;
  assign active  = (state_ff == lfp_pkg::ST_RUN) && dimS;

  // 1X window: current above the preset limit but below twice it.
  assign limitCond  = (state_ff == lfp_pkg::ST_RUN) && in1xS && !in2xS;
  assign latchCause = swOverS || lim2S || in2xS || limitHit;

  // ==========================================================================
  // Hold timers
  // ==========================================================================
  lfp_hold_timer #(.COUNT (lfp_pkg::SYNC_LOW_CYC), .W (TW)) u_syncLow (
    .clock (clock), .rst (rst), .cond (!syncS), .reached (syncLowHit)
  );

  lfp_hold_timer #(.COUNT (INPUT_UNDERVOLTAGE_LOCKOUT_FILT_CYC), .W (TW)) u_input_undervoltage_lockout (
    .clock (clock), .rst (rst), .cond (underS), .reached (uvloHit)
  );

  lfp_hold_timer #(.COUNT (LOWPOWER_CYC), .W (TW)) u_dimLow (
    .clock (clock), .rst (rst), .cond (!dimS), .reached (dimLowHit)
  );

  lfp_hold_timer #(.COUNT (LIMIT_1X_CYC), .W (TW)) u_limit (
    .clock (clock), .rst (rst), .cond (limitCond), .reached (limitHit)
  );

  // ==========================================================================
  // Supervisor state machine
  // ==========================================================================
  // Priority: undervoltage, low-power shutdown, latched faults, sync stop.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      lfp_pkg::ST_OFF: begin
        if (dimS && !underS) begin
          nxt_state = lfp_pkg::ST_DETECT;
        end
      end
      lfp_pkg::ST_DETECT: begin
        if (detCnt_ff == TW'(DETECT_CYC - 1)) begin
          nxt_state = lfp_pkg::ST_RUN;
        end
      end
      lfp_pkg::ST_RUN: begin
        nxt_state = lfp_pkg::ST_RUN;
      end
      lfp_pkg::ST_SYNCST: begin
        if (syncS) begin
          nxt_state = lfp_pkg::ST_DETECT;
        end
      end
      lfp_pkg::ST_LATCH: begin
        nxt_state = lfp_pkg::ST_LATCH;
      end
      default: begin
        nxt_state = lfp_pkg::ST_OFF;
      end
    endcase
    if (state_ff == lfp_pkg::ST_RUN || state_ff == lfp_pkg::ST_DETECT) begin
      if (latchCause) begin
        nxt_state = lfp_pkg::ST_LATCH;
      end else if (syncLowHit) begin
        nxt_state = lfp_pkg::ST_SYNCST;
      end
    end
    if (dimLowHit || uvloHit) begin
      nxt_state = lfp_pkg::ST_OFF;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_ff <= lfp_pkg::ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Detection phase length.
  always_ff @(posedge clock) begin
    if (rst || state_ff != lfp_pkg::ST_DETECT) begin
      detCnt_ff <= '0;
    end else begin
      detCnt_ff <= detCnt_ff + 1'b1;
    end
  end

  // ==========================================================================
  // String records
  // ==========================================================================
  // Shorted strings: caught at detection, added while sinking, rechecked on
  // each dimming rising edge; a fresh short beats the recheck clear.
  always_ff @(posedge clock) begin
    if (rst || nxt_state == lfp_pkg::ST_OFF) begin
      shortOut_ff <= '0;
    end else if (state_ff == lfp_pkg::ST_DETECT) begin
      shortOut_ff <= shortS;
    end else if (state_ff == lfp_pkg::ST_RUN && dimRise) begin
      shortOut_ff <= (shortOut_ff & shortS) | (shortS & sinkEnable_ff);
    end else if (state_ff == lfp_pkg::ST_RUN) begin
      shortOut_ff <= shortOut_ff | (shortS & sinkEnable_ff);
    end
  end

  // Open strings found while the output is at its overvoltage trip.
  always_ff @(posedge clock) begin
    if (rst || nxt_state == lfp_pkg::ST_OFF) begin
      openOut_ff <= '0;
    end else if (state_ff == lfp_pkg::ST_RUN && ovS) begin
      openOut_ff <= openOut_ff | (openS & sinkEnable_ff);
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  // Boost and sinks run only in operation with dimming enable high.
  always_ff @(posedge clock) begin
    if (rst) begin
      boostEnable_ff   <= 1'b0;
      boostCutCycle_ff <= 1'b0;
      sinkEnable_ff    <= '0;
    end else begin
      boostEnable_ff   <= active && !ovS && (nxt_state == lfp_pkg::ST_RUN);
      boostCutCycle_ff <= active && limS;
      sinkEnable_ff    <= (active && nxt_state == lfp_pkg::ST_RUN) ?
                          ~(shortOut_ff | openOut_ff) : '0;
    end
  end

  // Disconnect switch, flag and power state follow the next state directly.
  always_ff @(posedge clock) begin
    if (rst) begin
      disconnectGateOn_ff <= 1'b0;
      disconnectLimit_ff  <= 1'b0;
      faultFlag_ff        <= 1'b0;
      lowPower_ff         <= 1'b1;
    end else begin
      disconnectGateOn_ff <= (nxt_state == lfp_pkg::ST_RUN) ||
                             (nxt_state == lfp_pkg::ST_DETECT);
      disconnectLimit_ff  <= (nxt_state == lfp_pkg::ST_RUN) && limitCond;
      faultFlag_ff        <= (nxt_state == lfp_pkg::ST_LATCH) ||
                             ((nxt_state == lfp_pkg::ST_RUN) && limitCond);
      lowPower_ff         <= (nxt_state == lfp_pkg::ST_OFF);
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // Helper: consecutive cycles of 1X limiting.
  logic [TW:0] limRun_ff;
  always_ff @(posedge clock) begin
    if (rst || !disconnectLimit_ff) begin
      limRun_ff <= '0;
    end else begin
      limRun_ff <= limRun_ff + 1'b1;
    end
  end

  logic calm;
  assign calm = !uvloHit && !dimLowHit;

  short_record_a: assert property (
    state_ff == lfp_pkg::ST_RUN && nxt_state == lfp_pkg::ST_RUN && !dimRise
    |=> (shortOut_ff & $past(shortS & sinkEnable_ff)) == $past(shortS & sinkEnable_ff))
    else $error("new sink short not recorded");

  short_recheck_a: assert property (
    state_ff == lfp_pkg::ST_RUN && nxt_state == lfp_pkg::ST_RUN && dimRise
    |=> (shortOut_ff & ~$past(shortS)) == '0)
    else $error("cleared short not restored on dimming edge");

  ov_stop_a: assert property (
    ovS |=> !boostEnable_ff)
    else $error("boost ran during overvoltage");

  open_remove_a: assert property (
    state_ff == lfp_pkg::ST_RUN && nxt_state == lfp_pkg::ST_RUN && ovS
    |=> ##1 (sinkEnable_ff & $past(openS & sinkEnable_ff, 2)) == '0)
    else $error("open string still sinking");

  sw_over_latch_a: assert property (
    state_ff == lfp_pkg::ST_RUN && swOverS && calm
    |=> state_ff == lfp_pkg::ST_LATCH ##0
        (!boostEnable_ff && !disconnectGateOn_ff && sinkEnable_ff == '0))
    else $error("switch node overvoltage not latched off");

  latch_hold_a: assert property (
    state_ff == lfp_pkg::ST_LATCH && calm |=> state_ff == lfp_pkg::ST_LATCH && faultFlag_ff)
    else $error("latched fault released early");

  detect_first_a: assert property (
    $rose(boostEnable_ff) |-> $past(state_ff, 2) != lfp_pkg::ST_OFF)
    else $error("boost started without detection");

  cut_no_flag_a: assert property (
    active && limS && nxt_state == lfp_pkg::ST_RUN && !limitCond
    |=> boostCutCycle_ff && !faultFlag_ff)
    else $error("primary limit misbehaved");

  limit_bound_a: assert property (
    limRun_ff <= (TW+1)'(LIMIT_1X_CYC))
    else $error("1X limiting ran past its timer");

  flag_1x_a: assert property (
    nxt_state == lfp_pkg::ST_RUN && limitCond |=> faultFlag_ff && disconnectLimit_ff)
    else $error("1X entry did not raise the flag");

  flag_clear_a: assert property (
    nxt_state == lfp_pkg::ST_RUN && !limitCond |=> !faultFlag_ff && !disconnectLimit_ff)
    else $error("flag stayed after 1X cleared");

  sync_stop_a: assert property (
    state_ff == lfp_pkg::ST_RUN && syncLowHit && !latchCause && calm
    |=> state_ff == lfp_pkg::ST_SYNCST ##0 (!boostEnable_ff && !disconnectGateOn_ff))
    else $error("sync low did not stop the device");

  low_power_a: assert property (
    dimLowHit |=> lowPower_ff && shortOut_ff == '0 && openOut_ff == '0)
    else $error("low power entry failed");

  trip_2x_a: assert property (
    (state_ff == lfp_pkg::ST_RUN || state_ff == lfp_pkg::ST_DETECT) && in2xS && calm
    |=> !disconnectGateOn_ff && faultFlag_ff && state_ff == lfp_pkg::ST_LATCH)
    else $error("2X overcurrent not latched off");

  input_undervoltage_lockout_filter_a: assert property (
    state_ff == lfp_pkg::ST_RUN && underS && !uvloHit && !dimLowHit && !latchCause
    && !syncLowHit |=> state_ff == lfp_pkg::ST_RUN)
    else $error("short undervoltage dip shut the device");

  flag_source_a: assert property (
    faultFlag_ff |-> $past(nxt_state == lfp_pkg::ST_LATCH || limitCond))
    else $error("fault flag without a cause");

  run_c:    cover property (state_ff == lfp_pkg::ST_DETECT ##1 state_ff == lfp_pkg::ST_RUN);
  recheck_c: cover property (dimRise && shortOut_ff != '0);
  limit_c:  cover property (disconnectLimit_ff ##1 !disconnectLimit_ff && !faultFlag_ff);
  latch_c:  cover property (state_ff == lfp_pkg::ST_LATCH ##1 lowPower_ff);

endmodule
`default_nettype wire

// ---- hdl/lfp_hold_timer.sv ----
// Counts how long a condition has held without a break and flags the limit.
`timescale 1ns/1ps
`default_nettype none
module lfp_hold_timer #(
  parameter int COUNT = 8,
  parameter int W     = 16
) (
  input  wire logic clock,
  input  wire logic rst,
  input  wire logic cond,
  output logic      reached
);

  // ==========================================================================
  // Counter
  // ==========================================================================
  localparam logic [W-1:0] LIMIT = W'(COUNT);
  logic [W-1:0] cnt_ff;

  generate
    if (COUNT < 1 || COUNT >= (2 ** W)) begin : g_bad
      $error("lfp_hold_timer count does not fit its counter");
    end
  endgenerate

  // Any break in the condition restarts the count; it saturates at the limit.
  always_ff @(posedge clock) begin
    if (rst || !cond) begin
      cnt_ff <= '0;
    end else if (cnt_ff != LIMIT) begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  // High once the condition has held for COUNT edges in a row.
  assign reached = (cnt_ff == LIMIT);

endmodule
`default_nettype wire

// ---- hdl/lfp_pkg.sv ----
// Shared constants and types for the LED driver fault supervision block.
package lfp_pkg;

  // ==========================================================================
  // Clock and timing
  // ==========================================================================
  localparam int CLK_PERIOD_NS     = 10;
  localparam int SYNC_LOW_TIME_NS  = 7000;
  localparam int SYNC_LOW_CYC      = (SYNC_LOW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INPUT_UNDERVOLTAGE_LOCKOUT_FILT_TIME_NS = 50000;
  localparam int INPUT_UNDERVOLTAGE_LOCKOUT_FILT_CYC     = (INPUT_UNDERVOLTAGE_LOCKOUT_FILT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIP_2X_TIME_NS   = 3000;
  localparam int TRIP_2X_CYC       = TRIP_2X_TIME_NS / CLK_PERIOD_NS;
  localparam int LOWPOWER_CYC      = 32750;
  localparam int LIMIT_1X_CYC      = 10000;
  localparam int DETECT_CYC        = 64;
  localparam int NUM_STRINGS       = 4;
  localparam int TIMER_W           = 16;

  // ==========================================================================
  // Supervisor states
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_OFF    = 3'h0,
    ST_DETECT = 3'h1,
    ST_RUN    = 3'h2,
    ST_SYNCST = 3'h3,
    ST_LATCH  = 3'h4
  } lfp_state_type;

endpackage

// ---- hdl/lfp_sync.sv ----
// Two-stage synchroniser for a bus of independent pin levels.
`timescale 1ns/1ps
`default_nettype none
module lfp_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic [W-1:0] pinIn,
  output logic      [W-1:0] levelOut_ff
);

  // ==========================================================================
  // Stages
  // ==========================================================================
  logic [W-1:0] meta_ff;

  generate
    if (W < 1) begin : g_bad
      $error("lfp_sync width must be at least one");
    end
  endgenerate

  // The first stage feeds only the second stage.
  always_ff @(posedge clock) begin
    if (rst) begin
      meta_ff     <= '0;
      levelOut_ff <= '0;
    end else begin
      meta_ff     <= pinIn;
      levelOut_ff <= meta_ff;
    end
  end

endmodule
`default_nettype wire

// ---- verif/lfp_host_model.sv ----
// Host controller model that drives the dimming-enable and frequency/sync pins.
`timescale 1ns/1ps
`default_nettype none
module lfp_host_model (
  input  wire logic clock,
  output var  logic dimEnablePin,
  output var  logic freqSetSyncPin
);
  // ==========================================================================
  // Host intent, set by the bench, applied one cycle later to avoid races
  // ==========================================================================
  logic       dimLevel;
  int         syncMode;
  logic       dimNow;
  int         syncNow;
  logic [1:0] syncDiv;

  // Start disabled, with the sync pin idle high.
  initial begin
    dimEnablePin   = 1'b0;
    freqSetSyncPin = 1'b1;
    dimLevel       = 1'b0;
    syncMode       = 0;
    syncDiv        = 2'h0;
  end

  // Intent is sampled on the edge and the pins move a small fixed delay after it.
  always @(posedge clock) begin
    dimNow  = dimLevel;
    syncNow = syncMode;
    #1;
    syncDiv      = syncDiv + 2'h1;
    dimEnablePin = dimNow;  // Follows the level requested through set_dim; some low holds are too short to shut down.
    case (syncNow)
      1: freqSetSyncPin = syncDiv[1];  // External clock, low phases far below the stop time.
      2: freqSetSyncPin = 1'b0;  // Held low on purpose to force a stop.
      default: freqSetSyncPin = 1'b1;
    endcase
  end

  // Level requested on the dimming-enable pin.
  task automatic set_dim(input logic v);
    dimLevel = v;
  endtask

  // Sync pin mode: 0 idle high, 1 running clock, 2 held low.
  task automatic set_sync(input int m);
    syncMode = m;
  endtask
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking testbench for the LED driver fault supervision block.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // ==========================================================================
  // Shortened timer counts and bench signals
  // ==========================================================================
  localparam int UV_CYC = 20;
  localparam int LP_CYC = 40;
  localparam int L1_CYC = 30;
  localparam int DT_CYC = 4;

  logic       clock;
  logic       rst;
  wire logic  dimEnablePin;
  wire logic  freqSetSyncPin;
  logic [3:0] sinkShortPin;
  logic [3:0] sinkOpenPin;
  logic       ovSensePin;
  logic       switchLimitPin;
  logic [2:0] latchPins;
  logic       inputOver1xPin;
  logic       inputUnderPin;
  wire logic  boostEnable;
  wire logic  boostCut;
  wire logic [3:0] sinkEnable;
  wire logic  gateOn;
  wire logic  discLimit;
  wire logic  faultFlag;
  wire logic  lowPower;
  int         failures;
  int         totalChecks;

  lfp_host_model u_lfp_host_model (
    .clock          (clock),
    .dimEnablePin   (dimEnablePin),
    .freqSetSyncPin (freqSetSyncPin)
  );

  lfp_fault_ctrl #(.INPUT_UNDERVOLTAGE_LOCKOUT_FILT_CYC(UV_CYC), .LOWPOWER_CYC(LP_CYC),
                   .LIMIT_1X_CYC(L1_CYC), .DETECT_CYC(DT_CYC)) u_lfp_fault_ctrl (
    .clock (clock), .rst (rst), .dimEnablePin (dimEnablePin),
    .freqSetSyncPin (freqSetSyncPin), .sinkShortPin (sinkShortPin),
    .sinkOpenPin (sinkOpenPin), .ovSensePin (ovSensePin),
    .switchNodeOverPin (latchPins[2]), .switchLimitPin (switchLimitPin),
    .switchLimit2Pin (latchPins[1]), .inputOver1xPin (inputOver1xPin),
    .inputOver2xPin (latchPins[0]), .inputUnderPin (inputUnderPin),
    .boostEnable_ff (boostEnable), .boostCutCycle_ff (boostCut),
    .sinkEnable_ff (sinkEnable), .disconnectGateOn_ff (gateOn),
    .disconnectLimit_ff (discLimit), .faultFlag_ff (faultFlag), .lowPower_ff (lowPower)
  );

  // The clock toggles every half period of 5 ns.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  // ==========================================================================
  // Shared helpers
  // ==========================================================================
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Sets one pin group: 0 short, 1 open, 2 overvoltage, 3 switch limit,
  // 4 input 1X, 5 undervoltage, otherwise the three latching fault pins.
  task automatic drive(input int sel, input logic [3:0] v);
    case (sel)
      0: sinkShortPin = v;
      1: sinkOpenPin = v;
      2: ovSensePin = v[0];
      3: switchLimitPin = v[0];
      4: inputOver1xPin = v[0];
      5: inputUnderPin = v[0];
      default: latchPins = v[2:0];
    endcase
  endtask

  function automatic logic hit(input int sel);
    case (sel)
      0: return boostEnable === 1'b1;
      default: return lowPower === 1'b1;
    endcase
  endfunction

  // Bounded wait; running out of cycles counts as a mismatch and ends the run.
  task automatic wait_for(input int sel, input int limit);
    int i;
    i = 0;
    while (i < limit && !hit(sel)) begin
      cyc(1);
      i++;
    end
    if (!hit(sel)) begin
      failures++;
      $display("mismatch wait %0d expected 1 seen 0", sel);
      tally_and_finish();
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", totalChecks, failures);
    if (failures == 0 && totalChecks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic power_on();
    u_lfp_host_model.set_dim(1'b1);
    wait_for(0, DT_CYC + 14);
  endtask

  task automatic low_power();
    u_lfp_host_model.set_dim(1'b0);
    cyc(LP_CYC + 8);
    check("lowPower", 4'h1, {3'h0, lowPower});
    check("faultFlag", 4'h0, {3'h0, faultFlag});
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic s_enable();
    check("lowPower", 4'h1, {3'h0, lowPower});
    check("gateOn", 4'h0, {3'h0, gateOn});
    drive(0, 4'h4);
    u_lfp_host_model.set_dim(1'b1);
    cyc(5);
    check("boostEnable", 4'h0, {3'h0, boostEnable});
    wait_for(0, DT_CYC + 12);
    check("sinkEnable", 4'hb, sinkEnable);
    check("gateOn", 4'h1, {3'h0, gateOn});
  endtask

  task automatic s_short_recheck();
    drive(0, 4'h2);
    cyc(4);
    check("sinkEnable", 4'h9, sinkEnable);
    drive(0, 4'h0);
    cyc(6);
    check("sinkEnable", 4'h9, sinkEnable);
    u_lfp_host_model.set_dim(1'b0);
    cyc(5);
    u_lfp_host_model.set_dim(1'b1);
    cyc(8);
    check("sinkEnable", 4'hf, sinkEnable);
  endtask

  task automatic s_cycle_cut();
    drive(3, 4'h1);
    cyc(4);
    check("boostCut", 4'h1, {3'h0, boostCut});
    check("faultFlag", 4'h0, {3'h0, faultFlag});
    drive(3, 4'h0);
    cyc(4);
    check("boostCut", 4'h0, {3'h0, boostCut});
    check("boostEnable", 4'h1, {3'h0, boostEnable});
  endtask

  task automatic s_overvoltage();
    drive(1, 4'h8);
    drive(2, 4'h1);
    cyc(6);
    check("boostEnable", 4'h0, {3'h0, boostEnable});
    check("sinkEnable", 4'h7, sinkEnable);
    drive(2, 4'h0);
    drive(1, 4'h0);
    cyc(5);
    check("boostEnable", 4'h1, {3'h0, boostEnable});
    check("sinkEnable", 4'h7, sinkEnable);
  endtask

  task automatic s_one_x();
    drive(4, 4'h1);
    cyc(4);
    check("faultFlag", 4'h1, {3'h0, faultFlag});
    check("discLimit", 4'h1, {3'h0, discLimit});
    cyc(10);
    drive(4, 4'h0);
    cyc(4);
    check("faultFlag", 4'h0, {3'h0, faultFlag});
    check("discLimit", 4'h0, {3'h0, discLimit});
    drive(4, 4'h1);
    cyc(L1_CYC - 5);
    check("gateOn", 4'h1, {3'h0, gateOn});
    cyc(15);
    check("gateOn", 4'h0, {3'h0, gateOn});
    check("discLimit", 4'h0, {3'h0, discLimit});
    drive(4, 4'h0);
    cyc(6);
    check("faultFlag", 4'h1, {3'h0, faultFlag});
    low_power();
  endtask

  // Switch node over, secondary switch limit and 2X input current, one at a time.
  task automatic s_latched();
    for (int k = 2; k >= 0; k--) begin
      power_on();
      drive(6, 4'h1 << k);
      cyc(5);
      check("gateOn", 4'h0, {3'h0, gateOn});
      check("boostEnable", 4'h0, {3'h0, boostEnable});
      check("sinkEnable", 4'h0, sinkEnable);
      check("faultFlag", 4'h1, {3'h0, faultFlag});
      drive(6, 4'h0);
      u_lfp_host_model.set_dim(1'b0);
      cyc(6);
      u_lfp_host_model.set_dim(1'b1);
      cyc(8);
      check("faultFlag", 4'h1, {3'h0, faultFlag});
      check("gateOn", 4'h0, {3'h0, gateOn});
      if (k == 2) begin
        drive(5, 4'h1);
        cyc(UV_CYC + 6);
        check("lowPower", 4'h1, {3'h0, lowPower});
        u_lfp_host_model.set_dim(1'b0);
        drive(5, 4'h0);
        cyc(4);
      end else begin
        low_power();
      end
    end
  endtask

  task automatic s_under_glitch();
    power_on();
    drive(5, 4'h1);
    cyc(UV_CYC - 8);
    drive(5, 4'h0);
    cyc(6);
    check("lowPower", 4'h0, {3'h0, lowPower});
    check("boostEnable", 4'h1, {3'h0, boostEnable});
  endtask

  task automatic s_sync_stop();
    u_lfp_host_model.set_sync(1);
    cyc(20);
    check("boostEnable", 4'h1, {3'h0, boostEnable});
    u_lfp_host_model.set_sync(2);
    cyc(690);
    check("gateOn", 4'h1, {3'h0, gateOn});
    cyc(20);
    check("boostEnable", 4'h0, {3'h0, boostEnable});
    check("gateOn", 4'h0, {3'h0, gateOn});
    check("sinkEnable", 4'h0, sinkEnable);
    u_lfp_host_model.set_sync(1);
    wait_for(0, DT_CYC + 16);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  // ==========================================================================
  initial begin
    failures       = 0;
    totalChecks    = 0;
    rst            = 1'b1;
    for (int i = 0; i < 7; i++) begin
      drive(i, 4'h0);
    end
    cyc(20);
    rst = 1'b0;
    cyc(2);
    s_enable();
    s_short_recheck();
    s_cycle_cut();
    s_overvoltage();
    s_one_x();
    s_latched();
    s_under_glitch();
    s_sync_stop();
    tally_and_finish();
  end

  // Cuts a hung run short and reports it as a mismatch.
  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    $display("mismatch watchdog expected done seen running");
    tally_and_finish();
  end
endmodule
`default_nettype wire
